// ===== pkg/otp_port_pkg.sv
// Overview of operation
// [RQ1] command register writable only with test pin high
// [RQ2] start bit launches the encoded command
// [RQ3] 00 points at cell, 01 refreshes shadow
// [RQ4] 10 loads byte into chain, 11 zaps
// [RQ5] host keeps reserved bit four at zero
// [RQ6] address picks byte; data register carries data
// [RQ7] boost-off default taken from otp bit 108
package otp_port_pkg;
  localparam logic [7:0] OTP_CMD_OFFSET = 8'h09;
  localparam logic [7:0] OTP_DATA_OFFSET = 8'h0A;
  localparam int START_BIT = 7;
  localparam int RSVD_BIT = 4;
  localparam int CMD_LSB = 5;
  localparam int ADDR_LSB = 0;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int BOOST_OFF_OTP_BIT = 108;
  localparam int OTP_BYTES = 16;
  localparam int CMD_CYCLES = 1;
  typedef enum logic [1:0] {
    CMD_POINT = 2'b00,
    CMD_READ = 2'b01,
    CMD_LOAD = 2'b10,
    CMD_ZAP = 2'b11
  } otp_cmd_e;
endpackage : otp_port_pkg

// ===== hw/otp_command_port.sv
`timescale 1ns/10ps
module otp_command_port #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic test_pin,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [ADDR_W-1:0] otp_cell_addr,
  output logic [DATA_W-1:0] otp_wdata,
  output logic otp_point,
  output logic otp_read,
  output logic otp_load,
  output logic otp_zap,
  input wire logic [DATA_W-1:0] otp_rdata,
  input wire logic otp_bit_boost,
  output logic boost_off_bit,
  output logic busy
);
  import otp_port_pkg::*;

  // elaboration guard: the field slices below assume these sizes
  if (ADDR_W != 4 || DATA_W != 8 || (2 ** ADDR_W) != OTP_BYTES) begin : g_bad_width
    $error("otp_command_port supports only 4-bit address and 8-bit data");
  end

  if (CMD_CYCLES < 1 || CMD_CYCLES > 16) begin : g_bad_cycles
    $error("otp_command_port run length must be 1 to 16 cycles");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_POST = 3'b100
  } state_e;

  // test pin is asynchronous: two-stage synchroniser
  logic test_s1_q;
  logic test_s2_q;

  // command register held as separate fields
  logic start_q;
  logic start_d;
  logic [1:0] code_q;
  logic [1:0] code_d;
  logic rsvd_q;
  logic rsvd_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;

  logic [DATA_W-1:0] data_q;
  logic [DATA_W-1:0] data_d;
  logic [DATA_W-1:0] otp_rdata_q;
  logic boost_q;
  logic boost_load_q;
  logic [3:0] run_cnt_q;
  state_e state_q;
  state_e state_d;
  logic [3:0] op_hit;
  logic [7:0] cmd_view;

  // register decode
  wire cmd_sel = (reg_addr == OTP_CMD_OFFSET);
  wire data_sel = (reg_addr == OTP_DATA_OFFSET);
  wire idle = (state_q == ST_IDLE);
  wire run = (state_q == ST_RUN);
  wire post = (state_q == ST_POST);
  wire run_last = (run_cnt_q == 4'(CMD_CYCLES - 1));

  // command register writes during a command are dropped so the fields hold while it runs
  wire cmd_we = reg_wr && cmd_sel && test_s2_q && idle; // RQ1
  wire data_we = reg_wr && data_sel;
  wire start_req = cmd_we && reg_wdata[START_BIT]; // RQ2
  wire read_back = post && (code_q == CMD_READ); // RQ3

  // field next values
  assign start_d = cmd_we ? reg_wdata[START_BIT] : (post ? 1'b0 : start_q); // RQ2
  assign code_d = cmd_we ? reg_wdata[CMD_LSB+1:CMD_LSB] : code_q;
  // reserved bit stored as written; keeping it zero is up to the host
  assign rsvd_d = cmd_we ? reg_wdata[RSVD_BIT] : rsvd_q;
  assign addr_d = cmd_we ? reg_wdata[ADDR_LSB+ADDR_W-1:ADDR_LSB] : addr_q; // RQ6

  // a read result beats a same-cycle host write to the data register
  wire [DATA_W-1:0] host_data = data_we ? reg_wdata[DATA_W-1:0] : data_q;
  assign data_d = read_back ? otp_rdata_q : host_data; // RQ3 RQ6

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      test_s1_q <= 1'b0;
      test_s2_q <= 1'b0;
    end else if (clk_en) begin
      test_s1_q <= test_pin;
      test_s2_q <= test_s1_q;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_req) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (run_last) begin
          state_d = ST_POST;
        end
      end
      ST_POST: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // run phase length comes from the package, one cycle as built
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      run_cnt_q <= 4'h0;
    end else if (clk_en) begin
      run_cnt_q <= run ? run_cnt_q + 4'h1 : 4'h0;
    end
  end

  // start bit self-clears when the command finishes, so software can poll it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      start_q <= CMD_RESET[START_BIT];
    end else if (clk_en) begin
      start_q <= start_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      code_q <= CMD_RESET[CMD_LSB+1:CMD_LSB];
    end else if (clk_en) begin
      code_q <= code_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rsvd_q <= CMD_RESET[RSVD_BIT];
    end else if (clk_en) begin
      rsvd_q <= rsvd_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      addr_q <= CMD_RESET[ADDR_LSB+ADDR_W-1:ADDR_LSB];
    end else if (clk_en) begin
      addr_q <= addr_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      data_q <= DATA_RESET[DATA_W-1:0];
    end else if (clk_en) begin
      data_q <= data_d;
    end
  end

  // array byte sampled in the run cycle, written back one cycle later
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      otp_rdata_q <= '0;
    end else if (clk_en && run) begin
      otp_rdata_q <= otp_rdata;
    end
  end

  // default caught after reset release, not under reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      boost_q <= 1'b0;
      boost_load_q <= 1'b1;
    end else if (clk_en && boost_load_q) begin
      boost_q <= otp_bit_boost; // RQ7
      boost_load_q <= 1'b0;
    end
  end

  // one decode slice per command code
  for (genvar i = 0; i < 4; i++) begin : g_op
    assign op_hit[i] = run && (code_q == 2'(i)); // RQ3 RQ4
  end

  // pulses last the run phase only
  assign otp_point = op_hit[CMD_POINT]; // RQ3
  assign otp_read = op_hit[CMD_READ]; // RQ3
  assign otp_load = op_hit[CMD_LOAD]; // RQ4
  assign otp_zap = op_hit[CMD_ZAP]; // RQ4

  assign otp_cell_addr = addr_q; // RQ6
  assign otp_wdata = data_q; // RQ4 RQ6
  assign boost_off_bit = boost_q; // RQ7
  // busy covers run plus the write-back cycle
  assign busy = !idle;

  // read-back view rebuilt from the fields in their register positions
  assign cmd_view = {start_q, code_q, rsvd_q, addr_q};
  assign reg_rdata = cmd_sel ? cmd_view : (data_sel ? data_q : 8'h00);
endmodule : otp_command_port

// ===== tb/otp_asserts.sv
`timescale 1ns/10ps
module otp_asserts (
  input logic ref_clk,
  input logic srst,
  input logic clk_en,
  input logic test_pin,
  input logic [7:0] reg_addr,
  input logic reg_wr,
  input logic [7:0] reg_wdata,
  input logic busy,
  input logic otp_point,
  input logic otp_read,
  input logic otp_load,
  input logic otp_zap,
  input logic [3:0] otp_cell_addr,
  input logic otp_bit_boost,
  input logic boost_off_bit
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire any_op = otp_point || otp_read || otp_load || otp_zap;
  property p_lock; reg_wr && reg_addr == 8'h09 && !$past(test_pin, 2) |=> !$rose(busy);
  endproperty
  a_lock: assert property (p_lock) else $error("locked write started");
  property p_once; any_op |=> !any_op; endproperty
  a_once: assert property (p_once) else $error("pulse too long");
  property p_addr; any_op |-> otp_cell_addr == $past(reg_wdata[3:0]); endproperty
  a_addr: assert property (p_addr) else $error("cell address");
  property p_boost; $fell(srst) && clk_en |=> boost_off_bit == $past(otp_bit_boost);
  endproperty
  a_boost: assert property (p_boost) else $error("boost default");
  property p_go; $rose(busy) |-> $past(reg_wr && reg_wdata[7]); endproperty
  a_go: assert property (p_go) else $error("start");
  property p_tst; $rose(busy) |-> $past(test_pin, 3); endproperty
  a_tst: assert property (p_tst) else $error("test");
  property p_dec; $rose(busy) |-> {otp_point, otp_read, otp_load, otp_zap} ==
    4'b1000 >> $past(reg_wdata[6:5]); endproperty
  a_dec: assert property (p_dec) else $error("decode");
endmodule : otp_asserts
bind otp_command_port otp_asserts chk (.*);

// ===== tb/otp_model.sv
`timescale 1ns/10ps
module otp_model (
  input logic [3:0] otp_cell_addr,
  output logic [7:0] otp_rdata,
  output logic otp_bit_boost
);
  // address-tagged bytes expose a wrong cell
  assign otp_rdata = {~otp_cell_addr, otp_cell_addr};
  assign otp_bit_boost = 1'b1;
endmodule : otp_model

// ===== tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic ref_clk=0, srst=1, test_pin=0, reg_wr=0, otp_bit_boost, boost_off_bit, busy;
  logic [7:0] reg_addr=0, reg_wdata=0, reg_rdata, otp_rdata, otp_wdata;
  logic [3:0] otp_cell_addr;
  logic wr_busy;
  int n_errors=0, checks_done=0;
  initial forever #50 ref_clk = ~ref_clk;
  otp_command_port uut (.*, .clk_en(1'b1), .otp_point(), .otp_read(),
    .otp_load(), .otp_zap());
  otp_model otp (.*);
  task chk(logic [7:0] v, e, string s);
    checks_done++;
    if (v !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", s, e, v);
    end
  endtask : chk
  task wr(logic [7:0] a, d);
    @(posedge ref_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge ref_clk) reg_wr <= 0;
    // busy spans two cycles; peek mid-way, read back once idle
    #50;
    wr_busy = busy;
    #200;
  endtask : wr
  task finish_test;
    if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  initial #50000 begin
    n_errors++;
    finish_test;
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    srst <= 0;
    wr(8'h09, 8'h83);
    chk(reg_rdata, 8'h00, "locked");
    chk(boost_off_bit, 1'b1, "boost");
    chk(wr_busy, 1'b0, "refused start");
    @(posedge ref_clk) test_pin <= 1;
    repeat (2) @(posedge ref_clk);
    for (int c = 0; c < 4; c++) begin
      wr(8'h09, {1'b1, c[1:0], 5'(c + 4)});
      chk(wr_busy, 1'b1, "busy");
      chk(reg_rdata, {1'b0, c[1:0], 5'(c + 4)}, "cmd");
    end
    @(posedge ref_clk) reg_addr <= 8'h0A;
    @(negedge ref_clk) chk(reg_rdata, 8'hA5, "data");
    chk(otp_wdata, 8'hA5, "load");
    wr(8'h0A, 8'h3C);
    chk(reg_rdata, 8'h3C, "host data");
    chk(otp_wdata, 8'h3C, "write data");
    @(posedge ref_clk) reg_addr <= 8'h0B;
    @(negedge ref_clk) chk(reg_rdata, 8'h00, "unmapped");
    finish_test;
  end
endmodule : testbench
